// ===== ext_line_event_pkg.sv
// Constants, register map and carrier types of the line event controller.
// Assumes a 32-bit APB bus with word-aligned registers.
package ext_line_event_pkg;
  localparam int          NUM_LINES       = 29;
  localparam int          NUM_GPIO_LINES  = 16;
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] OFS_INT_ENABLE  = 12'h000;
  localparam logic [11:0] OFS_EVT_ENABLE  = 12'h004;
  localparam logic [11:0] OFS_RISE_SEL    = 12'h008;
  localparam logic [11:0] OFS_FALL_SEL    = 12'h00C;
  localparam logic [11:0] OFS_SW_TRIGGER  = 12'h010;
  localparam logic [11:0] OFS_PENDING     = 12'h014;
  localparam logic [11:0] OFS_SECURITY    = 12'h018;
  localparam logic [11:0] OFS_PRIVILEGE   = 12'h01C;
  localparam logic [11:0] OFS_LOCK        = 12'h020;
  localparam int          LOCK_BIT        = 0;
  localparam logic [28:0] LINE_RESET      = 29'h0000000;
  localparam logic [28:0] PENDING_RESET   = 29'h0000000;
  localparam logic [31:0] SECURE_BASE     = 32'h50013C00;
  localparam logic [31:0] NONSECURE_BASE  = 32'h40013C00;

  typedef logic [NUM_LINES-1:0] line_vec_t;

  // APB request fields; pprot[0] privileged, pprot[1] non-secure
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [2:0]        pprot;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_s;
endpackage

// ===== ext_line_event_controller.sv
// Register bank and edge logic of a 29-line interrupt and event controller.
// Assumes sources synchronous to pclk and an APB master that holds each request.
// Function
// - Each line has an interrupt enable gating its interrupt request
// - Each line has an event enable gating its event output
// - Rising-edge enable makes rising transitions count as requests
// - Falling-edge enable makes falling transitions count; both enables give either edge
// - Software trigger bit raised from zero by a write of one raises a request; writing zero clears the bit, pending stays
// - Pending flag is set when the line has been triggered with its interrupt enable set
// - Pending flag clears only by writing one; zero leaves it
// - Secure line: non-secure writes dropped, non-secure reads give zero
// - Privileged line: unprivileged writes dropped, unprivileged reads give zero
// - Non-secure write to security config ignored, flags illegal access; reads true
// - Privileged line's security bit written only by privileged access
// - Unprivileged write to privilege config dropped, flags illegal access; reads true
// - Secure line's privilege bit written only by secure access
// - Non-secure lock access ignored, reads zero, flags illegal access
// - Lock bit can be written once after each reset
// - Lock set blocks all changes to security and privilege config
// - Enable, edge, trigger and pending registers reset to zero
// - Same registers reached at a secure and a non-secure base
// - Interrupt trigger sets pending; event-only trigger leaves it untouched
// - Lines 0 to 15 from GPIO, 16 to 28 internal sources
//
// The APB register port is this design's own decision.
module ext_line_event_controller
  import ext_line_event_pkg::*;
#(
  parameter int LINES = NUM_LINES
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire ext_line_event_pkg::apb_req_s apb_req,
  output      ext_line_event_pkg::apb_rsp_s apb_rsp,
  input  wire ext_line_event_pkg::line_vec_t gpio_lines,
  input  wire ext_line_event_pkg::line_vec_t internal_lines,
  output      ext_line_event_pkg::line_vec_t line_irq,
  output      ext_line_event_pkg::line_vec_t line_event,
  output      logic                         illegal_access
);
  import ext_line_event_pkg::*;

  if (LINES != NUM_LINES) begin : g_check
    $error("LINES must equal NUM_LINES");
  end

  line_vec_t int_en;
  line_vec_t evt_en;
  line_vec_t rise_sel;
  line_vec_t fall_sel;
  line_vec_t sw_trig;
  line_vec_t pending;
  line_vec_t sec_cfg;
  line_vec_t priv_cfg;
  logic      lock;
  logic      lock_written;
  line_vec_t src_in;
  line_vec_t src_prev;
  line_vec_t access_ok;
  line_vec_t edge_hit;
  line_vec_t sw_hit;
  line_vec_t trig;
  line_vec_t wdata;
  line_vec_t next_sw;
  logic      wr;
  logic      rd;
  logic      non_secure;
  logic      unpriv;
  logic [31:0] next_rdata;
  logic        next_illegal;

  // Base select happens upstream; pprot carries the aperture used
  assign non_secure = apb_req.pprot[1];
  assign unpriv     = ~apb_req.pprot[0];
  assign wr    = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd    = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
  assign wdata = apb_req.pwdata[NUM_LINES-1:0];

  // Per-line filter for enable, edge, trigger and pending bits
  assign access_ok = ~(sec_cfg & {NUM_LINES{non_secure}})
                   & ~(priv_cfg & {NUM_LINES{unpriv}});

  // Low lines from GPIO, upper from internal wakeup sources
  assign src_in = {internal_lines[NUM_LINES-1:NUM_GPIO_LINES],
                   gpio_lines[NUM_GPIO_LINES-1:0]};

  assign edge_hit = (rise_sel & src_in & ~src_prev)
                  | (fall_sel & ~src_in & src_prev);

  // Software request fires on the write that raises the bit
  always_comb begin
    next_sw = sw_trig;
    if (wr && apb_req.paddr == OFS_SW_TRIGGER) begin
      next_sw = (sw_trig & ~access_ok) | (wdata & access_ok);
    end
  end
  assign sw_hit = next_sw & ~sw_trig;
  assign trig   = edge_hit | sw_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev <= LINE_RESET;
    end else begin
      src_prev <= src_in;
    end
  end

  // Line configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en   <= LINE_RESET;
      evt_en   <= LINE_RESET;
      rise_sel <= LINE_RESET;
      fall_sel <= LINE_RESET;
      sw_trig  <= LINE_RESET;
    end else begin
      sw_trig <= next_sw;
      if (wr) begin
        case (apb_req.paddr)
          OFS_INT_ENABLE: int_en   <= (int_en & ~access_ok) | (wdata & access_ok);
          OFS_EVT_ENABLE: evt_en   <= (evt_en & ~access_ok) | (wdata & access_ok);
          OFS_RISE_SEL:   rise_sel <= (rise_sel & ~access_ok) | (wdata & access_ok);
          OFS_FALL_SEL:   fall_sel <= (fall_sel & ~access_ok) | (wdata & access_ok);
          default: ;
        endcase
      end
    end
  end

  // Pending: set on interrupt-enabled trigger, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= PENDING_RESET;
    end else begin
      pending <= (pending
                  & ~((wr && apb_req.paddr == OFS_PENDING)
                      ? (wdata & access_ok) : LINE_RESET))
                 | (trig & int_en);
    end
  end

  // Security and privilege configuration with lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cfg  <= LINE_RESET;
      priv_cfg <= LINE_RESET;
    end else if (wr && !lock) begin
      if (apb_req.paddr == OFS_SECURITY && !non_secure) begin
        sec_cfg <= (sec_cfg & priv_cfg & {NUM_LINES{unpriv}})
                 | (wdata & ~(priv_cfg & {NUM_LINES{unpriv}}));
      end
      if (apb_req.paddr == OFS_PRIVILEGE && !unpriv) begin
        priv_cfg <= (priv_cfg & sec_cfg & {NUM_LINES{non_secure}})
                  | (wdata & ~(sec_cfg & {NUM_LINES{non_secure}}));
      end
    end
  end

  // Write-once lock; first secure write consumes the chance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock         <= 1'b0;
      lock_written <= 1'b0;
    end else if (wr && apb_req.paddr == OFS_LOCK && !non_secure && !lock_written) begin
      lock         <= apb_req.pwdata[LOCK_BIT];
      lock_written <= 1'b1;
    end
  end

  always_comb begin
    next_rdata   = 32'h00000000;
    next_illegal = 1'b0;
    case (apb_req.paddr)
      OFS_INT_ENABLE: next_rdata[NUM_LINES-1:0] = int_en & access_ok;
      OFS_EVT_ENABLE: next_rdata[NUM_LINES-1:0] = evt_en & access_ok;
      OFS_RISE_SEL:   next_rdata[NUM_LINES-1:0] = rise_sel & access_ok;
      OFS_FALL_SEL:   next_rdata[NUM_LINES-1:0] = fall_sel & access_ok;
      OFS_SW_TRIGGER: next_rdata[NUM_LINES-1:0] = sw_trig & access_ok;
      OFS_PENDING:    next_rdata[NUM_LINES-1:0] = pending & access_ok;
      OFS_SECURITY: begin
        next_rdata[NUM_LINES-1:0] = sec_cfg;
        next_illegal = wr & non_secure;
      end
      OFS_PRIVILEGE: begin
        next_rdata[NUM_LINES-1:0] = priv_cfg;
        next_illegal = wr & unpriv;
      end
      OFS_LOCK: begin
        next_rdata[LOCK_BIT] = lock & ~non_secure;
        next_illegal = (wr | rd) & non_secure;
      end
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Zero-wait slave: answer in the access cycle, read data registered at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_rsp        <= '0;
      illegal_access <= 1'b0;
    end else begin
      apb_rsp.pready  <= apb_req.psel & ~apb_req.penable;
      apb_rsp.pslverr <= 1'b0;
      if (apb_req.psel && !apb_req.penable) begin
        apb_rsp.prdata <= next_rdata;
      end
      illegal_access <= next_illegal;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_irq   <= LINE_RESET;
      line_event <= LINE_RESET;
    end else begin
      line_irq   <= (pending | (trig & int_en)) & int_en;
      line_event <= trig & evt_en;
    end
  end

  a_pending_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (trig & int_en) != '0 |=> (pending & $past(trig & int_en)) == $past(trig & int_en))
    else $error("pending not set by trigger");
  a_event_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    line_event == $past(trig & evt_en))
    else $error("event pulse wrong");
  a_event_no_pend: assert property (@(posedge pclk) disable iff (!presetn)
    (trig & ~int_en) != '0 && pending == '0 && !wr |=> (pending & $past(trig & ~int_en)) == '0)
    else $error("event-only set pending");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (line_irq == (($past(pending) | $past(trig & int_en)) & $past(int_en))))
    else $error("irq level wrong");
  a_lock_once: assert property (@(posedge pclk) disable iff (!presetn)
    lock_written |=> lock == $past(lock))
    else $error("lock changed twice");
  a_lock_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    lock |=> sec_cfg == $past(sec_cfg) && priv_cfg == $past(priv_cfg))
    else $error("config changed under lock");
  a_ns_sec_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && non_secure && apb_req.paddr == OFS_SECURITY |=> sec_cfg == $past(sec_cfg) && illegal_access)
    else $error("non-secure security write");
  a_up_priv_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && unpriv && apb_req.paddr == OFS_PRIVILEGE |=> priv_cfg == $past(priv_cfg) && illegal_access)
    else $error("unprivileged privilege write");
  a_ns_lock_zero: assert property (@(posedge pclk) disable iff (!presetn)
    apb_req.psel && !apb_req.penable && non_secure && apb_req.paddr == OFS_LOCK
      |=> apb_rsp.prdata == 32'h00000000)
    else $error("non-secure lock read nonzero");
  a_secure_read: assert property (@(posedge pclk) disable iff (!presetn)
    apb_req.psel && !apb_req.penable && apb_req.paddr == OFS_INT_ENABLE && non_secure
      |=> (apb_rsp.prdata[NUM_LINES-1:0] & $past(sec_cfg)) == '0)
    else $error("secure line leaked");
  a_ready_next: assert property (@(posedge pclk) disable iff (!presetn)
    apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("pready late");

  c_irq: cover property (@(posedge pclk) disable iff (!presetn) line_irq != '0);
  c_event: cover property (@(posedge pclk) disable iff (!presetn) line_event != '0);
  c_lock: cover property (@(posedge pclk) disable iff (!presetn) $rose(lock));
  c_illegal: cover property (@(posedge pclk) disable iff (!presetn) illegal_access);
endmodule

// ===== core_wake_model.sv
// Far-side model of the core's wake and interrupt logic: counts request pulses.
// Assumes event and illegal-access pulses last one pclk cycle.
module core_wake_model
  import ext_line_event_pkg::*;
(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire ext_line_event_pkg::line_vec_t line_event,
  input  wire logic                          illegal_access,
  output int                                 event_count,
  output int                                 illegal_count
);
  // One count per cycle, so a pulse held too long shows as extra counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_count   <= 0;
      illegal_count <= 0;
    end else begin
      event_count   <= event_count + int'(|line_event);
      illegal_count <= illegal_count + int'(illegal_access);
    end
  end
endmodule

// ===== tb.sv
// Self-checking bench of the line event controller over APB.
// Assumes the APB slave answers within 20 cycles of the access phase.
module tb;
  import ext_line_event_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] SP = 3'b001, SU = 3'b000, NP = 3'b011, NU = 3'b010;
  logic        pclk;
  logic        presetn;
  apb_req_s    apb_req;
  apb_rsp_s    apb_rsp;
  line_vec_t   gpio_lines, internal_lines, line_irq, line_event;
  logic        illegal_access;
  int          event_count, illegal_count, bad_count, check_count;
  logic [31:0] rd;

  ext_line_event_controller ext_line_event_controller_i (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .gpio_lines(gpio_lines),
    .internal_lines(internal_lines), .line_irq(line_irq), .line_event(line_event),
    .illegal_access(illegal_access));
  core_wake_model core_wake_model_i (.pclk(pclk), .presetn(presetn), .line_event(line_event),
    .illegal_access(illegal_access), .event_count(event_count), .illegal_count(illegal_count));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [2:0] p);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, d, p}; // Whole words, bits 31:29 zero
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    // Ready is judged at the rising edge only; the request stands until then
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (apb_rsp.pready !== 1'b1) begin
      $display("unexpected pready: expected 1 seen %b", apb_rsp.pready);
      bad_count++;
      stop_test();
    end
    rd = apb_rsp.prdata;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [2:0] p,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0, p);
    chk(nm, e, rd);
    chk("pslverr", 32'h0, 32'(apb_rsp.pslverr));
  endtask

  task automatic settle;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic t_reset;
    for (int i = 0; i <= 8; i++) if (i != 5) rdc("reset value", 12'(4 * i), SP, 32'h0);
    rdc("unmapped", 12'h024, SP, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_edges;
    apb(1'b1, OFS_INT_ENABLE, 32'h00000028, SP);
    apb(1'b1, OFS_RISE_SEL, 32'h00000008, SP);
    gpio_lines[3] <= 1'b1;
    settle();
    chk("irq3", 32'h1, 32'(line_irq[3]));
    rdc("pend", OFS_PENDING, SP, 32'h8);
    apb(1'b1, OFS_PENDING, 32'h0, SP);
    rdc("pend w0", OFS_PENDING, SP, 32'h8);
    apb(1'b1, OFS_PENDING, 32'h8, SP);
    settle();
    chk("irq clr", 32'h0, 32'(line_irq));
    gpio_lines[3] <= 1'b0;
    settle();
    rdc("fall off", OFS_PENDING, SP, 32'h0);
    $display("test edges done");
  endtask

  task automatic t_event;
    apb(1'b1, OFS_EVT_ENABLE, 32'h00020000, SP);
    apb(1'b1, OFS_FALL_SEL, 32'h00020000, SP);
    internal_lines[17] <= 1'b1;
    settle();
    chk("rise ign", 32'd0, 32'(event_count));
    internal_lines[17] <= 1'b0;
    settle();
    chk("evt cnt", 32'd1, 32'(event_count));
    rdc("evt pend", OFS_PENDING, SP, 32'h0);
    apb(1'b1, OFS_SW_TRIGGER, 32'h20, SP);
    settle();
    chk("sw irq", 32'h20, 32'(line_irq));
    rdc("sw pend", OFS_PENDING, SP, 32'h20);
    apb(1'b1, OFS_PENDING, 32'h20, SP);
    apb(1'b1, OFS_SW_TRIGGER, 32'h0, SP);
    rdc("sw off", OFS_SW_TRIGGER, SP, 32'h0);
    $display("test event done");
  endtask

  task automatic t_protect;
    apb(1'b1, OFS_SECURITY, 32'h8, SP);
    rdc("ns hide", OFS_INT_ENABLE, NP, 32'h20);
    apb(1'b1, OFS_INT_ENABLE, 32'h0, NP);
    rdc("ns drop", OFS_INT_ENABLE, SP, 32'h8);
    apb(1'b1, OFS_SECURITY, 32'h0, NP);
    rdc("ns sec", OFS_SECURITY, NP, 32'h8);
    apb(1'b1, OFS_PRIVILEGE, 32'h8, NP);
    rdc("ns priv", OFS_PRIVILEGE, SP, 32'h0);
    apb(1'b1, OFS_PRIVILEGE, 32'h100, SP);
    apb(1'b1, OFS_RISE_SEL, 32'h108, SP);
    rdc("up hide", OFS_RISE_SEL, SU, 32'h8);
    apb(1'b1, OFS_PRIVILEGE, 32'h0, SU);
    rdc("up priv", OFS_PRIVILEGE, SU, 32'h100);
    apb(1'b1, OFS_SECURITY, 32'h108, SU);
    rdc("up sec", OFS_SECURITY, SP, 32'h8);
    settle();
    chk("illegal", 32'd2, 32'(illegal_count));
    $display("test protect done");
  endtask

  task automatic t_lock;
    rdc("ns lock", OFS_LOCK, NP, 32'h0);
    apb(1'b1, OFS_LOCK, 32'h1, NP);
    rdc("lock ns w", OFS_LOCK, SP, 32'h0);
    apb(1'b1, OFS_LOCK, 32'h1, SP);
    apb(1'b1, OFS_LOCK, 32'h0, SP);
    rdc("lock once", OFS_LOCK, SP, 32'h1);
    apb(1'b1, OFS_SECURITY, 32'h0, SP);
    apb(1'b1, OFS_PRIVILEGE, 32'h0, SP);
    rdc("lock sec", OFS_SECURITY, SP, 32'h8);
    rdc("lock priv", OFS_PRIVILEGE, SP, 32'h100);
    settle();
    chk("illegal", 32'd4, 32'(illegal_count));
    $display("test lock done");
  endtask

  initial begin
    presetn        = 1'b0;
    apb_req        = '0;
    gpio_lines     = '0;
    internal_lines = '0;
    bad_count      = 0;
    check_count    = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_edges();
    t_event();
    t_protect();
    t_lock();
    stop_test();
  end
endmodule
